// ==== hdl/scii_pkg.sv ====
// Package: constants and carrier types for the sixteen channel input image
package scii_pkg;
	// ------------------------------------------------------------
	// Geometry and offsets
	// ------------------------------------------------------------
	localparam int NUM_CHANNELS = 16;
	localparam logic [0:0] IMAGE_OFFSET = 1'h0;
	localparam logic [15:0] IMAGE_RESET = 16'h0000;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLOCK_HZ = 100000000;
	localparam int FILTER_TIME_MS = 3;
	localparam int FILTER_CYCLES = (CLOCK_HZ / 1000) * FILTER_TIME_MS;
	localparam int FLASH_HALF_MS = 500;
	localparam int FLASH_HALF_CYCLES = (CLOCK_HZ / 1000) * FLASH_HALF_MS;
	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic error;
		logic config_error;
		logic bus_fail;
	} scii_health_t;
	typedef struct packed {
		logic green;
		logic red;
	} scii_status_led_t;
endpackage : scii_pkg

// ==== hdl/scii_input_image.sv ====
// Module: sixteen channel input image with filtering and indicators
`timescale 1ns/1ps
module scii_input_image #(
	parameter int FILTER_CYCLES = scii_pkg::FILTER_CYCLES,
	parameter int FLASH_HALF_CYCLES = scii_pkg::FLASH_HALF_CYCLES
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Field inputs
	input wire logic [15:0] field_input_channel_i,
	// Module health
	input wire scii_pkg::scii_health_t health_i,
	// Backplane register port
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic addr_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] rdata_o,
	output logic rvalid_o,
	// Indicators
	output logic [15:0] channel_led_o,
	output scii_pkg::scii_status_led_t status_led_o
);
	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [15:0] sync_a;
	logic [15:0] sync_b;
	logic [2:0] health_a;
	logic [2:0] health_b;
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			sync_a <= 16'h0000;
			sync_b <= 16'h0000;
			health_a <= 3'h0;
			health_b <= 3'h0;
		end
		else
		begin
			sync_a <= field_input_channel_i;
			sync_b <= sync_a;
			health_a <= health_i;
			health_b <= health_a;
		end
	end
	scii_pkg::scii_health_t health;
	assign health = health_b;
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Shared terminal count test, so filter and flash wrap the same way
	function automatic logic count_done(input logic [31:0] cnt, input int cycles);
		return cnt >= 32'(cycles - 1);
	endfunction : count_done
	// ------------------------------------------------------------
	// Per channel filter
	// ------------------------------------------------------------
	// A level must stand unchanged for the full time; bounces restart the count
	logic [15:0] process_input_image;
	logic [31:0] filt_cnt [16];
	always_ff @(posedge clock_i)
	begin
		for (int i = 0; i < scii_pkg::NUM_CHANNELS; i++)
		begin
			if (rst_i)
			begin
				filt_cnt[i] <= 32'h0;
				process_input_image[i] <= scii_pkg::IMAGE_RESET[i];
			end
			else if (sync_b[i] == process_input_image[i])
				filt_cnt[i] <= 32'h0;
			else if (count_done(filt_cnt[i], FILTER_CYCLES))
			begin
				filt_cnt[i] <= 32'h0;
				process_input_image[i] <= sync_b[i];
			end
			else
				filt_cnt[i] <= filt_cnt[i] + 32'h1;
		end
	end
	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	// Writes deliberately have no decode at all; the module owns no output bytes
	logic unused_wr;
	assign unused_wr = wr_i ^ (^wdata_i);
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			rdata_o <= 16'h0000;
			rvalid_o <= 1'b0;
		end
		else
		begin
			// Every read is answered, so the host never waits more than one cycle
			rvalid_o <= rd_i;
			if (rd_i && addr_i == scii_pkg::IMAGE_OFFSET)
				rdata_o <= process_input_image;
			else
				rdata_o <= 16'h0000;
		end
	end
	// ------------------------------------------------------------
	// Flash divider
	// ------------------------------------------------------------
	logic [31:0] flash_cnt;
	logic flash;
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			flash_cnt <= 32'h0;
			flash <= 1'b0;
		end
		else if (count_done(flash_cnt, FLASH_HALF_CYCLES))
		begin
			flash_cnt <= 32'h0;
			flash <= ~flash;
		end
		else
			flash_cnt <= flash_cnt + 32'h1;
	end
	// ------------------------------------------------------------
	// Indicators
	// ------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			channel_led_o <= 16'h0000;
			status_led_o <= '0;
		end
		else
		begin
			channel_led_o <= process_input_image;
			// Configuration error flash takes priority over steady error
			if (health.config_error)
				status_led_o.red <= flash;
			else
				status_led_o.red <= health.error;
			if (health.bus_fail)
				status_led_o.green <= flash;
			else
				status_led_o.green <= ~health.error & ~health.config_error;
		end
	end
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	read_image_a: assert property (@(posedge clock_i) disable iff (rst_i)
		rd_i && !addr_i |=> rvalid_o && rdata_o == $past(process_input_image))
		else $error("read data not image");
	byte_order_a: assert property (@(posedge clock_i) disable iff (rst_i)
		rvalid_o && !$past(addr_i) |-> rdata_o[7:0] == $past(process_input_image[7:0]))
		else $error("byte 0 wrong");
	write_ignored_a: assert property (@(posedge clock_i) disable iff (rst_i)
		wr_i && !rd_i |=> $stable(process_input_image) || $past(sync_b) != $past(process_input_image))
		else $error("write disturbed image");
	green_ok_a: assert property (@(posedge clock_i) disable iff (rst_i)
		health == 3'h0 ##1 health == 3'h0 |=> status_led_o.green)
		else $error("green not lit");
	red_error_a: assert property (@(posedge clock_i) disable iff (rst_i)
		health.error && !health.config_error |=> status_led_o.red)
		else $error("red not lit");
	red_flash_a: assert property (@(posedge clock_i) disable iff (rst_i)
		health.config_error |=> status_led_o.red == $past(flash))
		else $error("red not flashing");
	green_flash_a: assert property (@(posedge clock_i) disable iff (rst_i)
		health.bus_fail |=> status_led_o.green == $past(flash))
		else $error("green not flashing");
	channel_led_a: assert property (@(posedge clock_i) disable iff (rst_i)
		1'b1 |=> channel_led_o == $past(process_input_image))
		else $error("channel led mismatch");
	filter_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
		filt_cnt[0] != 32'h0 && filt_cnt[0] < 32'(FILTER_CYCLES - 1) |=> $stable(process_input_image[0]))
		else $error("image changed early");
	flash_period_a: assert property (@(posedge clock_i) disable iff (rst_i)
		$changed(flash) |-> flash_cnt == 32'h0)
		else $error("flash toggled off period");
	read_idle_a: assert property (@(posedge clock_i) disable iff (rst_i)
		!rd_i |=> !rvalid_o && rdata_o == 16'h0000)
		else $error("read answer held too long");
	other_addr_a: assert property (@(posedge clock_i) disable iff (rst_i)
		rd_i && addr_i |=> rvalid_o && rdata_o == 16'h0000)
		else $error("unmapped address not zero");
	byte_high_a: assert property (@(posedge clock_i) disable iff (rst_i)
		rvalid_o && !$past(addr_i) |-> rdata_o[15:8] == $past(process_input_image[15:8]))
		else $error("byte 1 wrong");
	write_silent_a: assert property (@(posedge clock_i) disable iff (rst_i)
		wr_i && !rd_i |=> !rvalid_o)
		else $error("write produced an answer");
	green_fault_a: assert property (@(posedge clock_i) disable iff (rst_i)
		(health.error || health.config_error) && !health.bus_fail |=> !status_led_o.green)
		else $error("green lit during fault");
	red_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
		!health.error && !health.config_error |=> !status_led_o.red)
		else $error("red lit without error");
	filter_take_a: assert property (@(posedge clock_i) disable iff (rst_i)
		count_done(filt_cnt[0], FILTER_CYCLES) && sync_b[0] != process_input_image[0]
		|=> process_input_image[0] == $past(sync_b[0]))
		else $error("settled level not taken");
	filter_restart_a: assert property (@(posedge clock_i) disable iff (rst_i)
		sync_b[0] == process_input_image[0] |=> filt_cnt[0] == 32'h0)
		else $error("bounce did not restart filter");
	flash_bound_a: assert property (@(posedge clock_i) disable iff (rst_i)
		flash_cnt < 32'(FLASH_HALF_CYCLES))
		else $error("flash counter overran");
endmodule : scii_input_image

// ==== verification/scii_host_model.sv ====
// Host model: reads and writes the module over the backplane port
`timescale 1ns/1ps
module scii_host_model (
	// Clock
	input wire logic clock_i,
	// Answer
	input wire logic [15:0] rdata_i,
	input wire logic rvalid_i,
	// Request
	output logic rd_o,
	output logic wr_o,
	output logic addr_o,
	output logic [15:0] wdata_o
);
	initial
	begin
		rd_o = 1'b0;
		wr_o = 1'b0;
		addr_o = 1'b0;
		wdata_o = 16'h0000;
	end
	task automatic read(input logic a, output logic [15:0] d, output logic ok);
		ok = 1'b0;
		@(posedge clock_i);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge clock_i);
		rd_o <= 1'b0;
		// Bounded wait, so a silent module cannot hang the run
		for (int i = 0; i < 4 && !ok; i++)
		begin
			#1;
			ok = (rvalid_i === 1'b1);
			d = rdata_i;
			if (!ok)
				@(posedge clock_i);
		end
	endtask : read
	task automatic write(input logic a, input logic [15:0] v);
		@(posedge clock_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= v;
		@(posedge clock_i);
		wr_o <= 1'b0;
	endtask : write
endmodule : scii_host_model

// ==== verification/scii_input_image_tb_top.sv ====
// Testbench for the sixteen channel input image
`timescale 1ns/1ps
module scii_input_image_tb_top;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic [15:0] field_input_channel_i = 16'h0000;
	scii_pkg::scii_health_t health_i = '0;
	logic rd_i, wr_i, addr_i, rvalid_o, ok;
	logic [15:0] wdata_i, rdata_o, channel_led_o, got;
	scii_pkg::scii_status_led_t status_led_o;
	int errors = 0;
	int cmp_count = 0;
	initial forever #5 clock_i = ~clock_i;
	// Short counts keep the run brief
	scii_input_image #(.FILTER_CYCLES(5), .FLASH_HALF_CYCLES(8)) i_scii_input_image (.clock_i(clock_i),
		.rst_i(rst_i), .field_input_channel_i(field_input_channel_i), .health_i(health_i), .rd_i(rd_i),
		.wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
		.channel_led_o(channel_led_o), .status_led_o(status_led_o));
	scii_host_model i_scii_host_model (.clock_i(clock_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o),
		.rd_o(rd_i), .wr_o(wr_i), .addr_o(addr_i), .wdata_o(wdata_i));
	// ----
	// Tasks
	// ----
	task automatic test_done();
		$display("comparisons %0d, errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic rd(input logic a, input logic [15:0] exp);
		i_scii_host_model.read(a, got, ok);
		if (!ok)
		begin
			errors++;
			test_done();
		end
		else
			chk("image", exp, got);
	endtask : rd
	task automatic pins(input logic [15:0] v, input int wait_cycles);
		@(posedge clock_i);
		field_input_channel_i <= v;
		repeat (wait_cycles) @(posedge clock_i);
	endtask : pins
	task automatic flips(input logic grn, input logic [1:0] lvl, input int exp);
		logic prev;
		logic [1:0] seen;
		int n;
		n = 0;
		prev = grn ? status_led_o.green : status_led_o.red;
		// A flashing led has no fixed phase, so only the steady one is compared
		seen = status_led_o;
		if (exp != 0)
			seen[grn] = lvl[grn];
		chk("led levels", {14'h0000, lvl}, {14'h0000, seen});
		repeat (32)
		begin
			@(posedge clock_i);
			#1;
			if ((grn ? status_led_o.green : status_led_o.red) !== prev)
				n++;
			prev = grn ? status_led_o.green : status_led_o.red;
		end
		chk("led flips", exp[15:0], n[15:0]);
	endtask : flips
	task automatic health(input logic [2:0] v);
		@(posedge clock_i);
		health_i <= v;
		repeat (6) @(posedge clock_i);
	endtask : health
	// ----
	// Sequence
	// ----
	initial
	begin
		repeat (6) @(posedge clock_i);
		rst_i <= 1'b0;
		rd(1'b0, 16'h0000);
		pins(16'ha5c3, 0);
		rd(1'b0, 16'h0000);
		repeat (10) @(posedge clock_i);
		rd(1'b0, 16'ha5c3);
		chk("channel leds", 16'ha5c3, channel_led_o);
		i_scii_host_model.write(1'b0, 16'hffff);
		rd(1'b0, 16'ha5c3);
		rd(1'b1, 16'h0000);
		pins(16'h5a3c, 1);
		pins(16'ha5c3, 12);
		rd(1'b0, 16'ha5c3);
		pins(16'h0000, 0);
		rd(1'b0, 16'ha5c3);
		repeat (10) @(posedge clock_i);
		rd(1'b0, 16'h0000);
		chk("channel leds", 16'h0000, channel_led_o);
		flips(1'b1, 2'b10, 0);
		health(3'b100);
		flips(1'b0, 2'b01, 0);
		health(3'b010);
		flips(1'b0, 2'b00, 4);
		health(3'b001);
		flips(1'b1, 2'b00, 4);
		test_done();
	end
endmodule : scii_input_image_tb_top
